// ### pkg/cfe_pkg.sv
// Constants, register map and state type of the converter control sequencer.
// Assumes a single 125 MHz clock; all times are converted to cycles here.
package cfe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rate and delays
  localparam int unsigned CLK_MHZ = 125;        // Reference clock in MHz
  localparam int unsigned UV_FILTER_US = 1000;  // Under-voltage filter time
  localparam int unsigned HICCUP_US = 16000;    // Hiccup restart delay
  localparam int unsigned UV_ARM_US = 1500;     // Arming delay after ramp
  localparam int unsigned PG_DELAY_US = 1000;   // Power-good release delay
  localparam int unsigned UV_FILTER_CYC = UV_FILTER_US * CLK_MHZ;
  localparam int unsigned HICCUP_CYC = HICCUP_US * CLK_MHZ;
  localparam int unsigned UV_ARM_CYC = UV_ARM_US * CLK_MHZ;
  localparam int unsigned PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 24;         // Delay counter width

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets and reset values
  localparam logic [7:0] OPERATION_OFS = 8'h01;
  localparam logic [7:0] GATE_CFG_OFS = 8'h02;
  localparam logic [7:0] STATUS_OFS = 8'h78;    // Sticky fault flags
  localparam logic [7:0] LIVE_OFS = 8'h79;      // Live sequencer state
  localparam logic [7:0] WARN_OFS = 8'h7a;      // Sticky warning flags
  localparam logic [7:0] OPERATION_RST = 8'h00;
  localparam logic [7:0] GATE_CFG_RST = 8'h16;
  localparam int unsigned ON_BIT = 7;           // On/off bit of operation

  ////////////////////////////////////////////////////////////////////////////
  // Gate configuration codes
  localparam logic [7:0] CFG_PIN = 8'h16;       // Pin alone
  localparam logic [7:0] CFG_CMD = 8'h1a;       // Command bit alone
  localparam logic [7:0] CFG_BOTH = 8'h1e;      // Pin and command bit
  localparam logic [7:0] CFG_OFF = 8'h12;       // Forced off
  localparam logic [3:0] CFG_ON_HI = 4'h0;      // Upper nibble of forced on

  ////////////////////////////////////////////////////////////////////////////
  // Fault flag positions in the status register
  localparam int unsigned F_UV = 0;
  localparam int unsigned F_OV = 1;
  localparam int unsigned F_OC = 2;
  localparam int unsigned F_OT = 3;
  localparam int unsigned F_LOCK = 4;
  localparam int unsigned F_N = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Delay timer indices
  localparam int unsigned T_HICCUP = 0;
  localparam int unsigned T_ARM = 1;
  localparam int unsigned T_UVF = 2;
  localparam int unsigned T_PG = 3;
  localparam int unsigned T_N = 4;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_OFF, ST_SOFTSTART, ST_RUN, ST_HICCUP
  } cfe_state_e;

endpackage

// ### pkg/cfe_timer_if.sv
// Hold-off timer link between the sequencer and one delay counter.
// The controller drives a restart level and a load value.
`timescale 1ns/100ps
interface cfe_timer_if #(
  parameter int unsigned W = 24
);
  logic start;          // Reload the count while high
  logic [W-1:0] load;   // Cycles to count once start falls
  logic expired;        // Count reached zero

  // Sequencer side
  modport ctrl (output start, output load, input expired);
  // Counter side
  modport tmr (input start, input load, output expired);
endinterface

// ### hw/cfe_sync2.sv
// Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes each bit is an independent level; no bus coherency is kept.
`timescale 1ns/100ps
module cfe_sync2 #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // Both stages; the first is read only by the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cfe_sync_s;

  cfe_sync_s q, d;

  // Shift one stage per edge
  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;
endmodule // cfe_sync2

// ### hw/cfe_timer.sv
// Hold-off delay counter: expires once start has stayed low long enough.
// Assumes the controller holds start high whenever the delay must restart.
`timescale 1ns/100ps
module cfe_timer #(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Controller link
  cfe_timer_if.tmr t
);
  // Remaining count
  typedef struct packed {
    logic [W-1:0] cnt;
  } cfe_tmr_s;

  cfe_tmr_s q, d;

  // Reload while start is high, else count down and hold at zero
  always_comb begin
    d = q;
    if (t.start) begin
      d.cnt = t.load;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - W'(1);
    end
  end

  // State register; all ones so nothing looks expired after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign t.expired = (q.cnt == '0);
endmodule // cfe_timer

// ### hw/cfe_sequencer.sv
// Enable gating, fault protection and status pins of a buck converter.
// Assumes analog comparators and a bus command decoder sit outside; all
// comparator and pin inputs are asynchronous and are synchronised here.
//
// Summary of operation
// R01: Overcurrent beyond limit counts as a short
// R02: Short: shut down, wait, restart, repeat forever
// R03: Recover by itself once the short goes
// R04: Power-good held low until soft start
// R05: Power-good released after threshold plus delay
// R06: Any fault latches power-good low until restart
// R07: Alert pin pulled low while any warning stored
// R08: Clear-faults resets all stored warning and fault flags
// R09: Feedback under 70% for 1 ms turns off
// R10: Under-voltage shutdown waits 16 ms hiccup delay
// R11: Under-voltage watched only 1.5 ms after ramp
// R12: Feedback over 120% turns on sinking mode
// R13: Sinking down to under-voltage restarts after hiccup
// R14: No start while over-voltage persists
// R15: Enable pin high enables, low disables
// R16: Configuration code selects pin, bit, both, off, on
// R17: Over-temperature shuts down, restarts when cooled
// R18: Delays are counters; alert released when flags clear
`timescale 1ns/100ps
module cfe_sequencer #(
  parameter int unsigned WARN_N = 4,
  parameter int unsigned TIMER_W = cfe_pkg::TIMER_W,
  parameter int unsigned UV_FILTER_CYC = cfe_pkg::UV_FILTER_CYC,
  parameter int unsigned HICCUP_CYC = cfe_pkg::HICCUP_CYC,
  parameter int unsigned UV_ARM_CYC = cfe_pkg::UV_ARM_CYC,
  parameter int unsigned PG_DELAY_CYC = cfe_pkg::PG_DELAY_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Enable pin and analog comparator levels, asynchronous
  input wire logic on_off_pin,
  input wire logic output_undervoltage_in,
  input wire logic output_overvoltage_in,
  input wire logic short_circuit_in,
  input wire logic overtemperature_in,
  input wire logic input_low_lockout_in,
  input wire logic soft_start_done_in,
  input wire logic fb_threshold_in,
  input wire logic [WARN_N-1:0] warn_in,
  // Power stage control
  output logic power_stage_en,
  output logic soft_start_run,
  output logic sink_mode_en,
  // Register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic clear_faults,
  // Open-drain power-good pin
  output logic output_ok_flag_o,
  output logic output_ok_flag_oe_n,
  // Open-drain alert pin
  output logic alert_n_o,
  output logic alert_n_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  localparam longint unsigned TMAX = (64'd1 << TIMER_W) - 64'd1;
  if (WARN_N < 1 || WARN_N > 8) begin : g_bad_warn
    $error("WARN_N must be 1 to 8");
  end
  if (HICCUP_CYC > TMAX || UV_FILTER_CYC > TMAX || UV_ARM_CYC > TMAX ||
      PG_DELAY_CYC > TMAX) begin : g_bad_timer
    $error("Delay count does not fit the timer width");
  end
  if (HICCUP_CYC < 1 || UV_FILTER_CYC < 1 || UV_ARM_CYC < 1 ||
      PG_DELAY_CYC < 1) begin : g_bad_zero
    $error("Delay counts must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output gating decode by configuration code
  function automatic logic cfe_gate(input logic [7:0] cfg,
                                    input logic cmd_on,
                                    input logic pin_on);
    logic on;
    on = 1'b0;
    if (cfg[7:4] == cfe_pkg::CFG_ON_HI) begin
      on = 1'b1;                          // Forced on [R16]
    end else if (cfg == cfe_pkg::CFG_PIN) begin
      on = pin_on;                        // Pin alone [R15] [R16]
    end else if (cfg == cfe_pkg::CFG_CMD) begin
      on = cmd_on;                        // Command bit alone [R16]
    end else if (cfg == cfe_pkg::CFG_BOTH) begin
      on = pin_on && cmd_on;              // Both must be on [R16]
    end else begin
      on = 1'b0;                          // Forced off and unknown codes
    end
    return on;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int unsigned IN_N = 8;
  logic [IN_N+WARN_N-1:0] raw_in;   // Asynchronous levels
  logic [IN_N+WARN_N-1:0] syn_in;   // Synchronised levels
  logic pin_s;                      // Enable pin
  logic uv_s;                       // Feedback below 70%
  logic ov_s;                       // Feedback above 120%
  logic sc_s;                       // Current beyond limit
  logic ot_s;                       // Over-temperature
  logic lock_s;                     // Input lockout
  logic ssd_s;                      // Ramp complete
  logic thr_s;                      // Feedback reached good threshold
  logic [WARN_N-1:0] warn_s;        // Bus warnings

  assign raw_in = {warn_in, fb_threshold_in, soft_start_done_in,
                   input_low_lockout_in, overtemperature_in,
                   short_circuit_in, output_overvoltage_in,
                   output_undervoltage_in, on_off_pin};

  cfe_sync2 #(.W(IN_N + WARN_N)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn_in)
  );

  assign pin_s = syn_in[0];
  assign uv_s = syn_in[1];
  assign ov_s = syn_in[2];
  assign sc_s = syn_in[3];
  assign ot_s = syn_in[4];
  assign lock_s = syn_in[5];
  assign ssd_s = syn_in[6];
  assign thr_s = syn_in[7];
  assign warn_s = syn_in[IN_N +: WARN_N];

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the sequencer
  typedef struct packed {
    cfe_pkg::cfe_state_e state;          // Sequencer state
    logic [7:0] op;                      // Operation register
    logic [7:0] cfg;                     // Gate configuration register
    logic [cfe_pkg::F_N-1:0] faults;     // Sticky fault flags
    logic [WARN_N-1:0] warns;            // Sticky warning flags
    logic armed;                         // Under-voltage watch armed
    logic pg_good;                       // Threshold plus delay seen
    logic pg_block;                      // Power-good latched low
    logic pwr_en;                        // Power stage enabled
    logic ss_run;                        // Ramp in progress
    logic sink;                          // Sinking mode
    logic pg_drive;                      // Pulling power-good low
    logic alert_drive;                   // Pulling alert low
    logic [7:0] rdata;                   // Read data
  } cfe_ctl_s;

  cfe_ctl_s q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Delay timers
  cfe_timer_if #(.W(TIMER_W)) tmr_if [cfe_pkg::T_N] ();
  localparam logic [TIMER_W-1:0] LOADS [cfe_pkg::T_N] = '{
    TIMER_W'(HICCUP_CYC), TIMER_W'(UV_ARM_CYC),
    TIMER_W'(UV_FILTER_CYC), TIMER_W'(PG_DELAY_CYC)
  };

  // One counter per delay [R18]
  for (genvar g = 0; g < cfe_pkg::T_N; g++) begin : g_tmr
    assign tmr_if[g].load = LOADS[g];
    cfe_timer #(.W(TIMER_W)) u_tmr (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .t(tmr_if[g])
    );
  end

  logic hic_done;   // Hiccup wait over
  logic arm_done;   // Arming delay over
  logic uvf_done;   // Under-voltage held long enough
  logic pg_done;    // Power-good delay over

  // Shutdown wait restarts on every entry to hiccup [R02] [R10]
  assign tmr_if[cfe_pkg::T_HICCUP].start = (q.state != cfe_pkg::ST_HICCUP);
  // Arming counts only while running after the ramp [R11]
  assign tmr_if[cfe_pkg::T_ARM].start = (q.state != cfe_pkg::ST_RUN);
  // Filter restarts whenever the low feedback goes away [R09]
  assign tmr_if[cfe_pkg::T_UVF].start =
    !(uv_s && q.armed && q.state == cfe_pkg::ST_RUN);
  // Release delay runs only once the threshold is reached [R05]
  assign tmr_if[cfe_pkg::T_PG].start =
    !(thr_s && (q.state == cfe_pkg::ST_SOFTSTART ||
                q.state == cfe_pkg::ST_RUN));

  assign hic_done = tmr_if[cfe_pkg::T_HICCUP].expired;
  assign arm_done = tmr_if[cfe_pkg::T_ARM].expired;
  assign uvf_done = tmr_if[cfe_pkg::T_UVF].expired;
  assign pg_done = tmr_if[cfe_pkg::T_PG].expired;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic run_ok;                          // Output wanted and allowed
  logic [cfe_pkg::F_N-1:0] fault_set;    // Faults seen this cycle

  always_comb begin
    d = q;
    fault_set = '0;
    // Gating request, blocked by heat and input lockout [R16] [R17]
    run_ok = cfe_gate(q.cfg, q.op[cfe_pkg::ON_BIT], pin_s) &&
             !ot_s && !lock_s;
    // Level faults are recorded whatever the state
    if (ot_s) begin
      fault_set[cfe_pkg::F_OT] = 1'b1;   // [R17]
    end
    if (lock_s) begin
      fault_set[cfe_pkg::F_LOCK] = 1'b1;
    end
    if (ov_s) begin
      fault_set[cfe_pkg::F_OV] = 1'b1;   // [R12]
    end

    // Sequencer
    case (q.state)
      cfe_pkg::ST_OFF: begin
        // Start only once over-voltage has gone [R14]
        if (run_ok && !ov_s) begin
          d.state = cfe_pkg::ST_SOFTSTART;
        end
      end
      cfe_pkg::ST_SOFTSTART: begin
        if (!run_ok) begin
          d.state = cfe_pkg::ST_OFF;             // [R15] [R17]
        end else if (sc_s) begin
          fault_set[cfe_pkg::F_OC] = 1'b1;       // Short [R01]
          d.state = cfe_pkg::ST_HICCUP;          // [R02]
        end else if (ssd_s) begin
          d.state = cfe_pkg::ST_RUN;
        end
      end
      cfe_pkg::ST_RUN: begin
        if (!run_ok) begin
          d.state = cfe_pkg::ST_OFF;             // [R15] [R17]
        end else if (sc_s) begin
          fault_set[cfe_pkg::F_OC] = 1'b1;       // Short [R01]
          d.state = cfe_pkg::ST_HICCUP;          // [R02]
        end else if (uvf_done) begin
          fault_set[cfe_pkg::F_UV] = 1'b1;
          d.state = cfe_pkg::ST_HICCUP;          // [R09] [R10]
        end else if (ov_s && uv_s) begin
          fault_set[cfe_pkg::F_UV] = 1'b1;
          d.state = cfe_pkg::ST_HICCUP;          // [R13]
        end
      end
      cfe_pkg::ST_HICCUP: begin
        // Retry forever, never latch off [R02] [R03]
        if (hic_done) begin
          if (!run_ok) begin
            d.state = cfe_pkg::ST_OFF;
          end else if (!ov_s) begin
            d.state = cfe_pkg::ST_SOFTSTART;     // [R14]
          end
        end
      end
      default: begin
        d.state = cfe_pkg::ST_OFF;
      end
    endcase

    // Under-voltage watch armed after the delay, dropped off run [R11]
    d.armed = (q.state == cfe_pkg::ST_RUN) && (q.armed || arm_done);

    // Power-good tracking
    if (q.state != cfe_pkg::ST_SOFTSTART &&
        d.state == cfe_pkg::ST_SOFTSTART) begin
      d.pg_block = 1'b0;                         // New ramp unlatches [R06]
      d.pg_good = 1'b0;
    end else if (d.state == cfe_pkg::ST_OFF ||
                 d.state == cfe_pkg::ST_HICCUP) begin
      d.pg_good = 1'b0;
    end else if (pg_done) begin
      d.pg_good = 1'b1;                          // [R05]
    end
    if (fault_set != '0) begin
      d.pg_block = 1'b1;                         // Latch low on fault [R06]
    end

    // Sticky flags; a new event wins over the clear [R08]
    d.faults = (q.faults & ~{cfe_pkg::F_N{clear_faults}}) | fault_set;
    d.warns = (q.warns & ~{WARN_N{clear_faults}}) | warn_s;

    // Operation and configuration writes
    if (reg_wr) begin
      if (reg_addr == cfe_pkg::OPERATION_OFS) begin
        d.op = reg_wdata;
      end else if (reg_addr == cfe_pkg::GATE_CFG_OFS) begin
        d.cfg = reg_wdata;
      end
    end

    // Read data, registered; unmapped offsets read zero
    if (reg_addr == cfe_pkg::OPERATION_OFS) begin
      d.rdata = q.op;
    end else if (reg_addr == cfe_pkg::GATE_CFG_OFS) begin
      d.rdata = q.cfg;
    end else if (reg_addr == cfe_pkg::STATUS_OFS) begin
      d.rdata = {3'h0, q.faults};
    end else if (reg_addr == cfe_pkg::LIVE_OFS) begin
      d.rdata = {1'h0, q.alert_drive, q.sink, q.armed,
                 !q.pg_drive, q.pwr_en, 2'(q.state)};
    end else if (reg_addr == cfe_pkg::WARN_OFS) begin
      d.rdata = 8'(q.warns);
    end else begin
      d.rdata = 8'h00;
    end

    // Registered outputs
    d.pwr_en = (d.state == cfe_pkg::ST_SOFTSTART) ||
               (d.state == cfe_pkg::ST_RUN);      // [R02]
    d.ss_run = (d.state == cfe_pkg::ST_SOFTSTART);
    d.sink = ov_s && d.pwr_en;                    // Pull output down [R12]
    d.pg_drive = !(d.pg_good && !d.pg_block);     // [R04] [R05] [R06]
    // Alert held until every stored flag is cleared [R07] [R18]
    d.alert_drive = (d.faults != '0) || (d.warns != '0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; power-good pulled low from reset [R04]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= cfe_pkg::ST_OFF;
      q.op <= cfe_pkg::OPERATION_RST;
      q.cfg <= cfe_pkg::GATE_CFG_RST;
      q.pg_block <= 1'b1;
      q.pg_drive <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign power_stage_en = q.pwr_en;
  assign soft_start_run = q.ss_run;
  assign sink_mode_en = q.sink;
  assign reg_rdata = q.rdata;
  // Open-drain pins: drive zero, enable low while pulling
  assign output_ok_flag_o = 1'b0;
  assign output_ok_flag_oe_n = !q.pg_drive;
  assign alert_n_o = 1'b0;
  assign alert_n_oe_n = !q.alert_drive;

endmodule // cfe_sequencer

// ### sim/cfe_plant_model.sv
// Power stage stand-in: ramps the output and reports its feedback level.
// Assumes registered enable and ramp levels.
`timescale 1ns/100ps
module cfe_plant_model #(
  parameter int unsigned RAMP_CYC = 6  // Ramp length, raise for a slow plant
) (
  // Clock
  input wire logic ref_clk,
  // From the sequencer
  input wire logic power_stage_en,
  input wire logic soft_start_run,
  // Comparator levels back to the sequencer
  output logic soft_start_done_in,
  output logic fb_threshold_in
);
  logic [7:0] on_q = 8'h00;  // Cycles the stage has been on
  // Count on time; a dropped stage starts the ramp over
  always @(posedge ref_clk) begin
    if (!power_stage_en) on_q <= 8'h00;
    else if (on_q != 8'hff) on_q <= on_q + 8'h01;
  end
  // Ramp reported done only while a ramp is requested
  assign soft_start_done_in = soft_start_run && (on_q >= 8'(RAMP_CYC));
  // Feedback settles two cycles after the ramp
  assign fb_threshold_in = on_q >= 8'(RAMP_CYC + 2);
endmodule // cfe_plant_model

// ### sim/cfe_seq_monitor.sv
// Checker on the sequencer top ports: protection and status pins.
// Assumes event inputs are held as levels for several cycles.
`timescale 1ns/100ps
module cfe_seq_monitor #(
  parameter int unsigned WARN_N = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Event and level inputs
  input wire logic output_undervoltage_in,
  input wire logic output_overvoltage_in,
  input wire logic short_circuit_in,
  input wire logic overtemperature_in,
  input wire logic input_low_lockout_in,
  input wire logic fb_threshold_in,
  input wire logic [WARN_N-1:0] warn_in,
  input wire logic clear_faults,
  // Watched outputs
  input wire logic power_stage_en,
  input wire logic sink_mode_en,
  input wire logic output_ok_flag_oe_n,
  input wire logic alert_n_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // No event input raised
  wire quiet = !(|warn_in) && !output_undervoltage_in &&
    !output_overvoltage_in && !short_circuit_in &&
    !overtemperature_in && !input_low_lockout_in;
  // Short held while the stage runs
  sequence s_trip;
    (short_circuit_in && power_stage_en) [*4];
  endsequence
  // Events gone long enough to leave the synchronisers
  sequence s_quiet;
    quiet [*5];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_short_trip: assert property (
    s_trip |-> ##[0:4] !power_stage_en) else $error("short ignored");
  a_hiccup_hold: assert property (
    $fell(power_stage_en) && short_circuit_in |=> !power_stage_en [*8])
    else $error("restart too early");
  a_pg_fault_low: assert property (
    $rose(output_overvoltage_in) |-> ##[1:6] !output_ok_flag_oe_n)
    else $error("power good kept high");
  a_pg_after_delay: assert property (
    $rose(output_ok_flag_oe_n) |->
    power_stage_en && $past(fb_threshold_in, 8)) else $error("pg early");
  a_no_ov_start: assert property (
    $rose(power_stage_en) |-> !output_overvoltage_in)
    else $error("start during overvoltage");
  a_sink_cause: assert property (
    $rose(sink_mode_en) |->
    $past(power_stage_en) && $past(output_overvoltage_in, 2))
    else $error("sink without cause");
  a_ot_stop: assert property (
    $rose(overtemperature_in) |-> ##[1:6] !power_stage_en)
    else $error("hot stage kept on");
  a_alert_warn: assert property (
    $rose(|warn_in) |-> ##[1:6] !alert_n_oe_n) else $error("alert idle");
  a_alert_free: assert property (
    s_quiet ##0 clear_faults |=> alert_n_oe_n) else $error("alert stuck");
endmodule // cfe_seq_monitor

bind cfe_sequencer cfe_seq_monitor #(.WARN_N(WARN_N)) u_cfe_seq_monitor (.*);

// ### sim/converter_fault_enable_control_test.sv
// Self-checking bench for the sequencer with a power stage stand-in.
// Assumes shortened delays: filter 20, hiccup 40, arm 30, pg 10 cycles.
`timescale 1ns/100ps
module converter_fault_enable_control_test;
  localparam int HIC = 40;  // Hiccup cycles set below
  logic ref_clk, rst_n, on_off_pin, reg_wr, clear_faults;
  logic output_undervoltage_in, output_overvoltage_in, short_circuit_in;
  logic overtemperature_in, input_low_lockout_in;
  logic soft_start_done_in, fb_threshold_in, power_stage_en;
  logic soft_start_run, sink_mode_en, output_ok_flag_o, output_ok_flag_oe_n;
  logic alert_n_o, alert_n_oe_n;
  logic [3:0] warn_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int num_errors = 0;
  int num_checks = 0;
  // Board pull-ups on the open-drain pins
  wire pg_w = output_ok_flag_oe_n ? 1'b1 : output_ok_flag_o;
  wire alert_w = alert_n_oe_n ? 1'b1 : alert_n_o;
  cfe_sequencer #(.UV_FILTER_CYC(20), .HICCUP_CYC(HIC), .UV_ARM_CYC(30),
    .PG_DELAY_CYC(10)) u_cfe_sequencer (.*);
  cfe_plant_model u_cfe_plant_model (.*);
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Compare once the edge has settled
  task chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task fin(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) reg_addr <= a;
    cyc(2);
    chk(reg_rdata, exp);
  endtask
  task clr();
    @(posedge ref_clk) clear_faults <= 1'b1;
    @(posedge ref_clk) clear_faults <= 1'b0;
  endtask
  // Stage enable check, low feedback pulse, pin off then on
  task stg(input logic e);
    chk({7'h00, power_stage_en}, {7'h00, e});
  endtask
  task uvp(input int n);
    output_undervoltage_in <= 1'b1;
    cyc(n);
    output_undervoltage_in <= 1'b0;
  endtask
  task repin(input int n);
    @(posedge ref_clk) on_off_pin <= 1'b0;
    cyc(n);
    on_off_pin <= 1'b1;
  endtask
  task close_out();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, write back, unmapped place
  task t_regs();
    chk(pg_w, 0);
    chk(alert_w, 1);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h16);
    wr(8'h02, 8'h1a);
    rd(8'h02, 8'h1a);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    fin("regs");
  endtask
  // Every gate code against bit and pin: {code, bit, pin, stage}
  task t_gate();
    logic [19:0] tab [9] = '{20'h16011, 20'h16100, 20'h1a101, 20'h1a010,
      20'h1e111, 20'h1e100, 20'h1e010, 20'h12110, 20'h05001};
    for (int i = 0; i < 9; i++) begin
      wr(8'h01, {tab[i][8], 7'h00});
      wr(8'h02, tab[i][19:12]);
      @(posedge ref_clk) on_off_pin <= tab[i][4];
      cyc(12);
      stg(tab[i][0]);
    end
    fin("gate");
  endtask
  // Power good waits for threshold plus delay
  task t_pg();
    wr(8'h02, 8'h16);
    repin(10);
    cyc(12);
    chk(pg_w, 0);
    cyc(40);
    chk(pg_w, 1);
    fin("pg");
  endtask
  // Hiccup on a lasting short, recovery once it goes
  task t_short();
    int n;
    clr();
    @(posedge ref_clk) short_circuit_in <= 1'b1;
    cyc(8);
    stg(0);
    chk(soft_start_run, 0);
    chk(pg_w, 0);
    n = 0;
    while (!power_stage_en && n < 300) begin
      cyc(1);
      n++;
    end
    chk(8'(n >= HIC - 8 && n <= HIC + 4), 1);
    cyc(8);
    stg(0);
    short_circuit_in <= 1'b0;
    cyc(HIC + 30);
    stg(1);
    rd(8'h78, 8'h04);
    fin("short");
  endtask
  // Under-voltage: ignored before arming, filtered, then hiccup
  task t_uv();
    repin(8);
    cyc(20);
    uvp(25);
    stg(1);
    cyc(30);
    uvp(12);
    stg(1);
    cyc(4);
    uvp(30);
    stg(0);
    cyc(20);
    stg(0);
    cyc(40);
    stg(1);
    fin("uv");
  endtask
  // Over-voltage sinks, trips at the low threshold, blocks restart
  task t_ov();
    @(posedge ref_clk) output_overvoltage_in <= 1'b1;
    cyc(6);
    chk(sink_mode_en, 1);
    uvp(6);
    stg(0);
    cyc(HIC + 20);
    stg(0);
    output_overvoltage_in <= 1'b0;
    cyc(10);
    stg(1);
    chk(sink_mode_en, 0);
    fin("ov");
  endtask
  // Lockout then over-temperature: stop, restart when gone
  task t_trip();
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk)
        {overtemperature_in, input_low_lockout_in} <= 2'(1 << i);
      cyc(8);
      stg(0);
      chk(pg_w, 0);
      {overtemperature_in, input_low_lockout_in} <= 2'b00;
      cyc(12);
      stg(1);
    end
    fin("trip");
  endtask
  // Alert follows stored flags; clearing needs the cause gone
  task t_alert();
    clr();
    cyc(3);
    chk(alert_w, 1);
    warn_in <= 4'h2;
    cyc(6);
    chk(alert_w, 0);
    rd(8'h7a, 8'h02);
    clr();
    cyc(2);
    chk(alert_w, 0);
    warn_in <= 4'h0;
    cyc(4);
    clr();
    cyc(2);
    chk(alert_w, 1);
    rd(8'h7a, 8'h00);
    rd(8'h78, 8'h00);
    fin("alert");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, on_off_pin, reg_wr, clear_faults, warn_in} = '0;
    {output_undervoltage_in, output_overvoltage_in, short_circuit_in} = '0;
    {overtemperature_in, input_low_lockout_in, reg_addr, reg_wdata} = '0;
    cyc(20);
    rst_n <= 1'b1;
    t_regs();
    t_gate();
    t_pg();
    t_short();
    t_uv();
    t_ov();
    t_trip();
    t_alert();
    close_out();
  end
  // Watchdog, about seven times the expected run
  initial begin
    cyc(5000);
    num_errors++;
    close_out();
  end
endmodule // converter_fault_enable_control_test
